/* File: src/charger_option_control_bits.sv */
// option register bank: monitor enables, comparator, latch-off, ship discharge, limits
`timescale 1ns/1ps
`default_nettype none
`include "charger_option_defines.svh"

// ==========================================================================
// register map
// 0x3b monitor_comparator_options: 11 discharge monitor, 10 power monitor, 9 gain,
//   7 reference, 6 polarity, 5:4 deglitch, 3 latch-off, 1 ship discharge
// 0x38 current_limit_source_options: 7 external limit, fixed ones at 9:8 and 2
// reserved bits ignore writes and read their fixed values
// reads answer one cycle after the strobe; writes land on the strobe edge

module charger_option_control_bits
  import charger_option_pkg::*;
#(
  parameter int LIMIT_W = 16,
  parameter cnt_t DEG_MID_CYC = 32'(`DEG_MID_CYC),
  parameter cnt_t DEG_LONG_CYC = 32'(`DEG_LONG_CYC),
  parameter cnt_t SHIP_CYC = 32'(`SHIP_CYC)
)(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_RD_VALID,
  output logic REG_ADDR_ERR,
  input wire logic COMPARATOR_INPUT_ABOVE,
  input wire logic SENSE_RES_20MOHM,
  input wire logic [LIMIT_W-1:0] CHARGE_LIMIT_REG,
  input wire logic [LIMIT_W-1:0] DISCHARGE_LIMIT_REG,
  input wire logic [LIMIT_W-1:0] EXTERNAL_CURRENT_LIMIT_PIN,
  output logic DISCHARGE_MONITOR_OUT_ENABLE,
  output logic POWER_MONITOR_OUT_ENABLE,
  output logic [3:0] POWER_MONITOR_GAIN,
  output logic COMPARATOR_REFERENCE_1V2,
  output logic COMPARATOR_ENABLE,
  output logic COMPARATOR_OUTPUT,
  output logic ADAPTER_SWITCH_ON,
  output logic REVERSE_BLOCKING_SWITCH_ON,
  output logic BATTERY_SENSE_NEGATIVE_NODE_SINK,
  output logic [LIMIT_W-1:0] CHARGE_LIMIT,
  output logic [LIMIT_W-1:0] DISCHARGE_LIMIT
);

  // ==========================================================================
  // state
  // one packed struct holds the bank; long counters live in the helpers
  typedef struct packed {
    // register fields
    logic discharge_monitor_out_enable;
    logic power_monitor_out_enable;
    logic power_monitor_gain_select;
    logic comparator_reference_select;
    logic comparator_polarity_select;
    deg_sel_e comparator_deglitch_select;
    logic power_path_latchoff_enable;
    logic external_limit_enable;
    // latch and derived outputs
    logic power_path_off;
    logic [3:0] gain;
    // read port
    logic [15:0] rdata;
    logic rd_valid;
    logic addr_err;
    // effective limits
    logic [LIMIT_W-1:0] chg_lim;
    logic [LIMIT_W-1:0] dchg_lim;
  } st_s;

  // power-on values; limits start at zero, then follow the inputs
  localparam st_s RST_ST = '{
    discharge_monitor_out_enable: `RST_DCHG_MON_EN,
    power_monitor_out_enable: `RST_PWR_MON_EN,
    power_monitor_gain_select: `RST_PWR_GAIN,
    comparator_reference_select: `RST_COMPARATOR_REFERENCE_SELECT,
    comparator_polarity_select: `RST_COMPARATOR_POLARITY_SELECT,
    comparator_deglitch_select: deg_sel_e'(`RST_DEG_SEL),
    power_path_latchoff_enable: `RST_LATCHOFF_EN,
    external_limit_enable: `RST_EXT_LIMIT_EN,
    power_path_off: 1'b0,
    gain: `GAIN_10M_HIGH,
    rdata: 16'h0000,
    rd_valid: 1'b0,
    addr_err: 1'b0,
    chg_lim: '0,
    dchg_lim: '0
  };

  st_s st_ff;
  st_s nxt_st;

  // links to the deglitch filter and the ship timer
  deg_if dg ();
  ship_if sh ();

  // decode strobes, comparator status and read views
  logic wr_moncmp;
  logic wr_limsrc;
  logic cmp_on;
  logic cmp_trip;
  logic [15:0] moncmp_view;
  logic [15:0] limsrc_view;

  // ==========================================================================
  // address decode
  // a write to another code changes nothing; only the error pulse shows it
  assign wr_moncmp = REG_WR && (REG_ADDR == `OPT_MONCMP_ADDR);
  assign wr_limsrc = REG_WR && (REG_ADDR == `OPT_LIMSRC_ADDR);

  // ==========================================================================
  // comparator path
  // field 00 turns the comparator off and parks the filter input at its below-threshold level
  assign cmp_on = (st_ff.comparator_deglitch_select != DEG_OFF);

  // hazard: the filter idles high whatever the polarity, so turning polarity to 1
  // while the input is below threshold holds the output high for one deglitch
  // interval; with latch-off enabled that reads as a trip, so set polarity first
  // polarity: 0 gives low above threshold, 1 gives high above threshold
  always_comb begin
    // disabled: park raw at the below-threshold level so no trip follows
    if (!cmp_on) begin
      dg.raw = ~st_ff.comparator_polarity_select;
    end else if (st_ff.comparator_polarity_select) begin
      dg.raw = COMPARATOR_INPUT_ABOVE;
    end else begin
      dg.raw = ~COMPARATOR_INPUT_ABOVE;
    end
  end

  // deglitch length for falling edges of the output
  // the short count follows the clock period; the long ones are parameters
  always_comb begin
    case (st_ff.comparator_deglitch_select)
      DEG_SHORT: dg.delay_cyc = 32'(`DEG_SHORT_CYC);
      DEG_MID: dg.delay_cyc = DEG_MID_CYC;
      DEG_LONG: dg.delay_cyc = DEG_LONG_CYC;
      default: dg.delay_cyc = 32'h1;
    endcase
  end

  fall_deglitch u_deglitch (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .dg(dg.filter)
  );

  // tripped means the filtered output sits at its above-threshold level
  assign cmp_trip = cmp_on && (dg.filt == st_ff.comparator_polarity_select);

  // ==========================================================================
  // ship-mode discharge timer control
  // a write with the bit at 0 aborts, a 1 restarts the interval
  // start and stop come straight from the strobe, with no extra cycle
  assign sh.start = wr_moncmp && REG_WDATA[`BIT_SHIP_DCHG];
  assign sh.stop = wr_moncmp && !REG_WDATA[`BIT_SHIP_DCHG];

  ship_discharge_timer #(
    .SHIP_CYC(SHIP_CYC)
  ) u_ship (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .sh(sh.timer)
  );

  // ==========================================================================
  // read views, reserved bits fixed
  // the ship bit reads the timer, so it drops by itself when the interval ends
  always_comb begin
    moncmp_view = 16'h0000;
    moncmp_view[`BIT_DCHG_MON_EN] = st_ff.discharge_monitor_out_enable;
    moncmp_view[`BIT_PWR_MON_EN] = st_ff.power_monitor_out_enable;
    moncmp_view[`BIT_PWR_GAIN] = st_ff.power_monitor_gain_select;
    moncmp_view[`BIT_COMPARATOR_REFERENCE_SELECT] = st_ff.comparator_reference_select;
    moncmp_view[`BIT_COMPARATOR_POLARITY_SELECT] = st_ff.comparator_polarity_select;
    moncmp_view[`BIT_DEG_HI:`BIT_DEG_LO] = st_ff.comparator_deglitch_select;
    moncmp_view[`BIT_LATCHOFF_EN] = st_ff.power_path_latchoff_enable;
    moncmp_view[`BIT_SHIP_DCHG] = sh.active;
  end

  always_comb begin
    limsrc_view = `LIMSRC_FIXED_ONES;
    limsrc_view[`BIT_EXT_LIMIT_EN] = st_ff.external_limit_enable;
  end

  // ==========================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    // register writes, only the documented fields are stored
    if (wr_moncmp) begin
      nxt_st.discharge_monitor_out_enable = REG_WDATA[`BIT_DCHG_MON_EN];
      nxt_st.power_monitor_out_enable = REG_WDATA[`BIT_PWR_MON_EN];
      nxt_st.power_monitor_gain_select = REG_WDATA[`BIT_PWR_GAIN];
      nxt_st.comparator_reference_select = REG_WDATA[`BIT_COMPARATOR_REFERENCE_SELECT];
      nxt_st.comparator_polarity_select = REG_WDATA[`BIT_COMPARATOR_POLARITY_SELECT];
      nxt_st.comparator_deglitch_select = deg_sel_e'(REG_WDATA[`BIT_DEG_HI:`BIT_DEG_LO]);
      nxt_st.power_path_latchoff_enable = REG_WDATA[`BIT_LATCHOFF_EN];
    end
    if (wr_limsrc) begin
      nxt_st.external_limit_enable = REG_WDATA[`BIT_EXT_LIMIT_EN];
    end

    // latch-off: a trip sets it, a cleared enable releases it a cycle later
    // a trip in the clearing write's own cycle can still turn the switches off for one
    // cycle; the cleared enable still wins on the next edge
    if (!st_ff.power_path_latchoff_enable) begin
      nxt_st.power_path_off = 1'b0;
    end else if (cmp_trip) begin
      nxt_st.power_path_off = 1'b1;
    end

    // power monitor gain in quarter uA/W steps
    // 1 and 4 with 10 mOhm sense resistors, 2 and 8 with 20 mOhm on a path
    case ({SENSE_RES_20MOHM, st_ff.power_monitor_gain_select})
      2'b00: nxt_st.gain = `GAIN_10M_LOW;
      2'b01: nxt_st.gain = `GAIN_10M_HIGH;
      2'b10: nxt_st.gain = `GAIN_20M_LOW;
      2'b11: nxt_st.gain = `GAIN_20M_HIGH;
      default: nxt_st.gain = `GAIN_10M_HIGH;
    endcase

    // current limit source
    // pin and registers share units, so a plain compare picks the lower
    if (!st_ff.external_limit_enable) begin
      nxt_st.chg_lim = CHARGE_LIMIT_REG;
      nxt_st.dchg_lim = DISCHARGE_LIMIT_REG;
    end else begin
      nxt_st.chg_lim = (EXTERNAL_CURRENT_LIMIT_PIN < CHARGE_LIMIT_REG) ?
                       EXTERNAL_CURRENT_LIMIT_PIN : CHARGE_LIMIT_REG;
      nxt_st.dchg_lim = (EXTERNAL_CURRENT_LIMIT_PIN < DISCHARGE_LIMIT_REG) ?
                        EXTERNAL_CURRENT_LIMIT_PIN : DISCHARGE_LIMIT_REG;
    end

    // read answer one cycle after the strobe, unmapped codes read zero
    // a read and a write on one code in one cycle return the old value
    nxt_st.rd_valid = REG_RD;
    nxt_st.addr_err = (REG_RD || REG_WR) && (REG_ADDR != `OPT_MONCMP_ADDR) &&
                      (REG_ADDR != `OPT_LIMSRC_ADDR);
    if (REG_RD) begin
      if (REG_ADDR == `OPT_MONCMP_ADDR) begin
        nxt_st.rdata = moncmp_view;
      end else if (REG_ADDR == `OPT_LIMSRC_ADDR) begin
        nxt_st.rdata = limsrc_view;
      end else begin
        nxt_st.rdata = 16'h0000;
      end
    end
  end

  // ==========================================================================
  // state register, synchronous reset
  // reset also clears a held latch-off, as power-on must
  // and returns the bank to its read values 0x0210 and 0x0384
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  // both switches share one latch, so they always move together
  // data outputs come from flip-flops; the comparator enable follows the field
  assign REG_RDATA = st_ff.rdata;
  assign REG_RD_VALID = st_ff.rd_valid;
  assign REG_ADDR_ERR = st_ff.addr_err;
  assign DISCHARGE_MONITOR_OUT_ENABLE = st_ff.discharge_monitor_out_enable;
  assign POWER_MONITOR_OUT_ENABLE = st_ff.power_monitor_out_enable;
  assign POWER_MONITOR_GAIN = st_ff.gain;
  assign COMPARATOR_REFERENCE_1V2 = st_ff.comparator_reference_select;
  assign COMPARATOR_ENABLE = cmp_on;
  assign COMPARATOR_OUTPUT = dg.filt;
  assign ADAPTER_SWITCH_ON = ~st_ff.power_path_off;
  assign REVERSE_BLOCKING_SWITCH_ON = ~st_ff.power_path_off;
  assign BATTERY_SENSE_NEGATIVE_NODE_SINK = sh.active;
  assign CHARGE_LIMIT = st_ff.chg_lim;
  assign DISCHARGE_LIMIT = st_ff.dchg_lim;

endmodule

`default_nettype wire

/* File: src/charger_option_defines.svh */
// offsets, field positions, reset values and timing counts of the option block
`ifndef CHARGER_OPTION_DEFINES_SVH
`define CHARGER_OPTION_DEFINES_SVH

// ==========================================================================
// register command codes
`define OPT_MONCMP_ADDR 8'h3b
`define OPT_LIMSRC_ADDR 8'h38

// ==========================================================================
// monitor_comparator_options field positions
`define BIT_DCHG_MON_EN 11
`define BIT_PWR_MON_EN 10
`define BIT_PWR_GAIN 9
`define BIT_COMPARATOR_REFERENCE_SELECT 7
`define BIT_COMPARATOR_POLARITY_SELECT 6
`define BIT_DEG_HI 5
`define BIT_DEG_LO 4
`define BIT_LATCHOFF_EN 3
`define BIT_SHIP_DCHG 1

// current_limit_source_options field positions and fixed bits
`define BIT_EXT_LIMIT_EN 7
`define LIMSRC_FIXED_ONES 16'h0304

// ==========================================================================
// reset values
`define RST_DCHG_MON_EN 1'b0
`define RST_PWR_MON_EN 1'b0
`define RST_PWR_GAIN 1'b1
`define RST_COMPARATOR_REFERENCE_SELECT 1'b0
`define RST_COMPARATOR_POLARITY_SELECT 1'b0
`define RST_DEG_SEL 2'b01
`define RST_LATCHOFF_EN 1'b0
`define RST_EXT_LIMIT_EN 1'b1

// ==========================================================================
// power monitor gain in units of 0.25 uA/W
`define GAIN_10M_LOW 4'h1
`define GAIN_10M_HIGH 4'h4
`define GAIN_20M_LOW 4'h2
`define GAIN_20M_HIGH 4'h8

// ==========================================================================
// timing: figures in their own unit, counts derived at the 10 ns clock
`define CLK_PERIOD_NS 10
`define DEG_SHORT_US 1
`define DEG_MID_MS 2
`define DEG_LONG_S 5
`define SHIP_TIME_MS 140
`define DEG_SHORT_CYC ((`DEG_SHORT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEG_MID_CYC ((`DEG_MID_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEG_LONG_CYC ((64'd`DEG_LONG_S * 64'd1000000000 + 64'd9) / 64'd`CLK_PERIOD_NS)
`define SHIP_CYC ((`SHIP_TIME_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: src/charger_option_pkg.sv */
// types shared by the option block and its helpers
package charger_option_pkg;
  // comparator deglitch field
  typedef enum logic [1:0] {
    DEG_OFF = 2'b00,
    DEG_SHORT = 2'b01,
    DEG_MID = 2'b10,
    DEG_LONG = 2'b11
  } deg_sel_e;

  typedef logic [31:0] cnt_t;
endpackage

/* File: src/option_link_if.sv */
// interfaces between the option block and its deglitch and ship timer helpers
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// comparator deglitch link
interface deg_if;
  import charger_option_pkg::*;
  logic raw;
  cnt_t delay_cyc;
  logic filt;
  modport filter (input raw, input delay_cyc, output filt);
  modport ctrl (output raw, output delay_cyc, input filt);
endinterface

// ==========================================================================
// ship-mode discharge timer link
interface ship_if;
  logic start;
  logic stop;
  logic active;
  modport timer (input start, input stop, output active);
  modport ctrl (output start, output stop, input active);
endinterface

`default_nettype wire

/* File: src/fall_deglitch.sv */
// falling-edge deglitch filter for the comparator output
`timescale 1ns/1ps
`default_nettype none

module fall_deglitch
  import charger_option_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  deg_if.filter dg
);
  typedef struct packed {
    logic filt;
    cnt_t cnt;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  // ==========================================================================
  // rising passes at once, falling waits for delay_cyc low cycles
  always_comb begin
    nxt_st = st_ff;
    if (dg.raw) begin
      nxt_st.filt = 1'b1;
      nxt_st.cnt = '0;
    end else if (st_ff.filt) begin
      if (st_ff.cnt >= dg.delay_cyc - 32'h1) begin
        nxt_st.filt = 1'b0;
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 32'h1;
      end
    end
  end

  // state register, idle high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '{filt: 1'b1, cnt: 32'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dg.filt = st_ff.filt;
endmodule

`default_nettype wire

/* File: src/ship_discharge_timer.sv */
// one-shot timer that holds the ship-mode discharge sink on
`timescale 1ns/1ps
`default_nettype none

module ship_discharge_timer
  import charger_option_pkg::*;
#(
  parameter cnt_t SHIP_CYC = 32'd14000000
)(
  input wire logic clk,
  input wire logic rst_n,
  ship_if.timer sh
);
  typedef struct packed {
    logic active;
    cnt_t cnt;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  // ==========================================================================
  // start restarts the interval and wins over expiry and stop
  always_comb begin
    nxt_st = st_ff;
    if (sh.start) begin
      nxt_st.active = 1'b1;
      nxt_st.cnt = '0;
    end else if (sh.stop) begin
      nxt_st.active = 1'b0;
      nxt_st.cnt = '0;
    end else if (st_ff.active) begin
      if (st_ff.cnt >= SHIP_CYC - 32'h1) begin
        nxt_st.active = 1'b0;
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 32'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '{active: 1'b0, cnt: 32'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sh.active = st_ff.active;
endmodule

`default_nettype wire

/* File: sim/charger_option_control_bits_sva.sv */
// port-level assertion checker for the option register bank
`timescale 1ns/1ps
`default_nettype none
`include "charger_option_defines.svh"

module charger_option_control_bits_sva
  import charger_option_pkg::*;
#(
  parameter int LIMIT_W = 16
)(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_ADDR_ERR,
  input wire logic COMPARATOR_INPUT_ABOVE,
  input wire logic [LIMIT_W-1:0] CHARGE_LIMIT_REG,
  input wire logic [LIMIT_W-1:0] EXTERNAL_CURRENT_LIMIT_PIN,
  input wire logic DISCHARGE_MONITOR_OUT_ENABLE,
  input wire logic POWER_MONITOR_OUT_ENABLE,
  input wire logic COMPARATOR_REFERENCE_1V2,
  input wire logic COMPARATOR_ENABLE,
  input wire logic COMPARATOR_OUTPUT,
  input wire logic ADAPTER_SWITCH_ON,
  input wire logic REVERSE_BLOCKING_SWITCH_ON,
  input wire logic BATTERY_SENSE_NEGATIVE_NODE_SINK,
  input wire logic [LIMIT_W-1:0] CHARGE_LIMIT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  // ==========================================================================
  // shadow copies of the fields the assertions depend on
  wire logic w3b = REG_WR && REG_ADDR == `OPT_MONCMP_ADDR;
  wire logic w38 = REG_WR && REG_ADDR == `OPT_LIMSRC_ADDR;
  wire logic bad = REG_ADDR != `OPT_MONCMP_ADDR && REG_ADDR != `OPT_LIMSRC_ADDR;
  logic pol_ff;
  logic lat_ff;
  logic en_ff;
  logic ext_ff;
  wire logic raw = pol_ff ? COMPARATOR_INPUT_ABOVE : !COMPARATOR_INPUT_ABOVE;
  wire logic pin_low = ext_ff && EXTERNAL_CURRENT_LIMIT_PIN < CHARGE_LIMIT_REG;
  wire logic [LIMIT_W-1:0] lim = pin_low ? EXTERNAL_CURRENT_LIMIT_PIN : CHARGE_LIMIT_REG;

  // shadow registers load on the same write edge as the bank
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      pol_ff <= 1'b0;
      lat_ff <= 1'b0;
      en_ff <= 1'b1;
      ext_ff <= 1'b1;
    end else begin
      if (w3b) begin
        pol_ff <= REG_WDATA[6];
        lat_ff <= REG_WDATA[3];
        en_ff <= REG_WDATA[5:4] != 2'b00;
      end
      if (w38) begin
        ext_ff <= REG_WDATA[7];
      end
    end
  end

  // ==========================================================================
  // properties
  property p_dmon; w3b |=> DISCHARGE_MONITOR_OUT_ENABLE == $past(REG_WDATA[11]); endproperty
  property p_system_power_monitor; w3b |=> POWER_MONITOR_OUT_ENABLE == $past(REG_WDATA[10]); endproperty
  property p_ref; w3b |=> COMPARATOR_REFERENCE_1V2 == $past(REG_WDATA[7]); endproperty
  property p_cen; w3b |=> COMPARATOR_ENABLE == ($past(REG_WDATA[5:4]) != 2'b00); endproperty
  property p_rise; en_ff && raw && !REG_WR |-> ##[1:2] COMPARATOR_OUTPUT; endproperty
  property p_trip;
    lat_ff && en_ff && COMPARATOR_OUTPUT == pol_ff && !REG_WR |=> !ADAPTER_SWITCH_ON;
  endproperty
  property p_hold; !ADAPTER_SWITCH_ON && lat_ff && !REG_WR |=> !ADAPTER_SWITCH_ON; endproperty
  property p_rel; w3b && !REG_WDATA[3] |-> ##2 ADAPTER_SWITCH_ON; endproperty
  property p_pair; ADAPTER_SWITCH_ON == REVERSE_BLOCKING_SWITCH_ON; endproperty
  property p_ship; w3b && REG_WDATA[1] |=> BATTERY_SENSE_NEGATIVE_NODE_SINK [*8]; endproperty
  property p_lim; !REG_WR |=> CHARGE_LIMIT == $past(lim); endproperty
  property p_err; (REG_WR || REG_RD) && bad |=> REG_ADDR_ERR; endproperty

  a_dmon: assert property (p_dmon) else $error("discharge monitor enable mismatch");
  a_system_power_monitor: assert property (p_system_power_monitor) else $error("power monitor enable mismatch");
  a_ref: assert property (p_ref) else $error("comparator reference mismatch");
  a_cen: assert property (p_cen) else $error("comparator enable mismatch");
  a_rise: assert property (p_rise) else $error("comparator rise delayed");
  a_trip: assert property (p_trip) else $error("latch-off not taken");
  a_hold: assert property (p_hold) else $error("latch-off not held");
  a_rel: assert property (p_rel) else $error("latch-off not released");
  a_pair: assert property (p_pair) else $error("switch controls differ");
  a_ship: assert property (p_ship) else $error("ship discharge sink not running");
  a_lim: assert property (p_lim) else $error("charge limit mismatch");
  a_err: assert property (p_err) else $error("unmapped access not flagged");

  // main scenarios reached
  c_trip: cover property (!ADAPTER_SWITCH_ON);
  c_ship: cover property ($rose(BATTERY_SENSE_NEGATIVE_NODE_SINK));
  c_err: cover property (REG_ADDR_ERR);
endmodule

bind charger_option_control_bits charger_option_control_bits_sva #(.LIMIT_W(LIMIT_W)) u_sva (.*);

`default_nettype wire

/* File: sim/host_model.sv */
// host model issuing register writes and reads on the strobe port
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rd_valid,
  input wire logic addr_err
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
  end

  // one-cycle write strobe; released data shows its inverse
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    wdata = ~d;
  endtask

  // one-cycle read strobe, answer taken in the following cycle
  task automatic read(input logic [7:0] a, output logic [15:0] d, output logic e);
    @(posedge clk);
    #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rd_valid ? rdata : 16'hxxxx;
    e = addr_err;
  endtask
endmodule

`default_nettype wire

/* File: sim/charger_option_control_bits_tb.sv */
// self-checking testbench for the option register bank
`timescale 1ns/1ps
`default_nettype none

module charger_option_control_bits_tb;
  import charger_option_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic above = 1'b0;
  logic sense = 1'b0;
  logic [15:0] chg = 16'd100;
  logic [15:0] dchg = 16'd30;
  logic [15:0] pin = 16'd50;
  logic wr, rd, valid, aerr, dmon, system_power_monitor, ref12, cen, cout, asw, rsw, sink;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, clim, dlim;
  logic [3:0] gain;
  logic [3:0] gtab [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;

  // ==========================================================================
  // clock, host and design
  always #5 clk = ~clk;

  host_model host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rd_valid(valid), .addr_err(aerr));

  charger_option_control_bits #(.DEG_MID_CYC(32'd20), .DEG_LONG_CYC(32'd40),
    .SHIP_CYC(32'd50)) DUT (
    .CLK_SYS(clk), .RESET_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RD_VALID(valid), .REG_ADDR_ERR(aerr),
    .COMPARATOR_INPUT_ABOVE(above), .SENSE_RES_20MOHM(sense), .CHARGE_LIMIT_REG(chg),
    .DISCHARGE_LIMIT_REG(dchg), .EXTERNAL_CURRENT_LIMIT_PIN(pin),
    .DISCHARGE_MONITOR_OUT_ENABLE(dmon), .POWER_MONITOR_OUT_ENABLE(system_power_monitor),
    .POWER_MONITOR_GAIN(gain), .COMPARATOR_REFERENCE_1V2(ref12), .COMPARATOR_ENABLE(cen),
    .COMPARATOR_OUTPUT(cout), .ADAPTER_SWITCH_ON(asw), .REVERSE_BLOCKING_SWITCH_ON(rsw),
    .BATTERY_SENSE_NEGATIVE_NODE_SINK(sink), .CHARGE_LIMIT(clim), .DISCHARGE_LIMIT(dlim));

  // ==========================================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic e;
    host.read(a, d, e);
    check(what, d, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // falling edge waits the selected count, rising edge passes at once
  task automatic deg(input logic [1:0] f, input int n);
    int k;
    host.write(8'h3b, {10'h000, f, 4'h0});
    tick(3);
    check("rise", cout, 1'b1);
    above = 1'b1;
    k = 0;
    while (cout !== 1'b0 && k < n + 10) begin
      tick(1);
      k++;
    end
    check("deglitch", k >= n && k <= n + 3, 1'b1);
    above = 1'b0;
    tick(1);
    check("rise fast", cout, 1'b1);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end

  // ==========================================================================
  // test sequence
  initial begin
    logic [15:0] d;
    logic e;
    int k;
    tick(2);
    rst_n = 1'b1;
    rdchk("moncmp reset", 8'h3b, 16'h0210);
    rdchk("limsrc reset", 8'h38, 16'h0384);
    host.read(8'h10, d, e);
    check("unmapped data", d, 16'h0000);
    check("unmapped flag", e, 1'b1);
    $display("test reset done");
    host.write(8'h3b, 16'hfd85);
    rdchk("moncmp fields", 8'h3b, 16'h0c80);
    check("dmon on", dmon, 1'b1);
    check("system_power_monitor on", system_power_monitor, 1'b1);
    check("ref 1v2", ref12, 1'b1);
    check("cmp off", cen, 1'b0);
    for (int i = 0; i < 4; i++) begin
      sense = i[1];
      host.write(8'h3b, {6'h00, i[0], 9'h010});
      tick(2);
      check("gain", gain, gtab[i]);
    end
    check("dmon off", dmon, 1'b0);
    check("system_power_monitor off", system_power_monitor, 1'b0);
    check("ref 2v3", ref12, 1'b0);
    $display("test fields done");
    host.write(8'h38, 16'h0000);
    rdchk("limsrc off", 8'h38, 16'h0304);
    check("chg reg", clim, 16'd100);
    check("dchg reg", dlim, 16'd30);
    host.write(8'h38, 16'hffff);
    rdchk("limsrc on", 8'h38, 16'h0384);
    check("chg pin", clim, 16'd50);
    check("dchg reg low", dlim, 16'd30);
    pin = 16'd10;
    tick(2);
    check("dchg pin", dlim, 16'd10);
    $display("test limits done");
    deg(2'b01, 100);
    deg(2'b10, 20);
    deg(2'b11, 40);
    host.write(8'h3b, 16'h0050);
    tick(110);
    check("pol below", cout, 1'b0);
    above = 1'b1;
    tick(3);
    check("pol above", cout, 1'b1);
    $display("test comparator done");
    above = 1'b0;
    host.write(8'h3b, 16'h0018);
    tick(3);
    check("switch idle", asw, 1'b1);
    above = 1'b1;
    tick(110);
    check("trip out", cout, 1'b0);
    check("latched", asw, 1'b0);
    above = 1'b0;
    tick(5);
    check("held", asw, 1'b0);
    check("held rb", rsw, 1'b0);
    host.write(8'h3b, 16'h0010);
    tick(2);
    check("released", asw, 1'b1);
    check("released rb", rsw, 1'b1);
    above = 1'b1;
    host.write(8'h3b, 16'h0018);
    tick(110);
    check("relatched", asw, 1'b0);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    above = 1'b0;
    check("reset release", asw, 1'b1);
    rdchk("moncmp reset again", 8'h3b, 16'h0210);
    $display("test latch done");
    host.write(8'h3b, 16'h0012);
    check("sink on", sink, 1'b1);
    rdchk("ship running", 8'h3b, 16'h0012);
    k = 0;
    while (sink === 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    check("ship time", k >= 47 && k <= 49, 1'b1);
    rdchk("ship cleared", 8'h3b, 16'h0010);
    check("sink off", sink, 1'b0);
    $display("test ship done");
    test_done();
  end
endmodule

`default_nettype wire
